//--- rtl/monitor_readback_port.sv
// Read side of the two-wire serial slave of a power monitor
`include "monitor_readback_params.svh"
`default_nettype none
module monitor_readback_port (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	// Serial link pins
	input  wire logic        sclIn,
	input  wire logic        sdaIn,
	output var  logic        sdaOut,
	output var  logic        sdaOe,
	// Slave address
	input  wire logic [6:0]  slaveAddr,
	// Command state from the write side
	input  wire logic        volt_free_run,
	input  wire logic        voltOnce,
	input  wire logic        amp_free_run,
	input  wire logic        ampOnce,
	input  wire logic        statusReadSel,
	input  wire logic        voltage_span_select,
	// Conversion results
	input  wire logic [11:0] voltCode,
	input  wire logic [11:0] ampCode,
	input  wire logic        conversionDone,
	// Alert sources
	input  wire logic        sampled_overcurrent_now,
	input  wire logic        adcTripEvent,
	input  wire logic        analog_trip_off_state,
	input  wire logic        insertionFailEvent,
	input  wire logic        latchOffVariant,
	input  wire logic        insertion_fail_notice_on,
	input  wire logic        powerRequestPin,
	input  wire logic        soft_power_down,
	input  wire logic        offAlertEvent,
	input  wire logic        clearRequest,
	// Observed state
	output var  logic [7:0]  alertStatusOut,
	output var  logic        clearPendingOut,
	output var  logic        readActive
);

	logic                        sclSync;
	logic                        sdaSync;
	logic                        sclPrev_q;
	logic                        sdaPrev_q;
	logic                        sclRise;
	logic                        sclFall;
	logic                        startCond;
	logic                        stopCond;
	monitor_readback_pkg::phase_e phase_q;
	monitor_readback_pkg::frame_e frame_q;
	logic [3:0]                  bitCnt_q;
	logic [7:0]                  shift_q;
	logic [1:0]                  byteIdx_q;
	logic                        dataValid_q;
	logic                        singlePending_q;
	logic                        singleSeen_q;
	logic [7:0]                  alertStatus;
	logic                        clearPending;
	logic [7:0]                  txByte;
	logic [1:0]                  lastIdx;
	logic                        freeRunNow;
	logic                        powerRequestSync;

	// Both link pins are asynchronous, so each passes two flops
	pin_sync sclSyncInst (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.asyncIn (sclIn),
		.syncOut (sclSync)
	);
	pin_sync sdaSyncInst (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.asyncIn (sdaIn),
		.syncOut (sdaSync)
	);

	// Power request is a board pin, so it is retimed before the status byte
	pin_sync reqSyncInst (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.asyncIn (powerRequestPin),
		.syncOut (powerRequestSync)
	);

	// Status flags live in their own module
	alert_status_flags flagsInst (
		.ref_clk                  (ref_clk),
		.arst_n                   (arst_n),
		.sampled_overcurrent_now  (sampled_overcurrent_now),
		.adcTripEvent             (adcTripEvent),
		.analog_trip_off_state    (analog_trip_off_state),
		.insertionFailEvent       (insertionFailEvent),
		.latchOffVariant          (latchOffVariant),
		.insertion_fail_notice_on (insertion_fail_notice_on),
		.powerRequestOff          (~powerRequestSync),
		.soft_power_down          (soft_power_down),
		.offAlertEvent            (offAlertEvent),
		.clearRequest             (clearRequest),
		.clearPending             (clearPending),
		.alertStatus              (alertStatus)
	);

	// Edge and condition detection on synchronised pins
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sclPrev_q <= 1'b1;
			sdaPrev_q <= 1'b1;
		end else begin
			sclPrev_q <= sclSync;
			sdaPrev_q <= sdaSync;
		end
	end
	assign sclRise   = sclSync & ~sclPrev_q;
	assign sclFall   = ~sclSync & sclPrev_q;
	assign startCond = sclSync & sclPrev_q & sdaPrev_q & ~sdaSync;
	assign stopCond  = sclSync & sclPrev_q & ~sdaPrev_q & sdaSync;
	assign freeRunNow = volt_free_run | amp_free_run;

	// Track single-shot requests; reads are refused until one completes
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			singlePending_q <= 1'b0;
			singleSeen_q    <= 1'b0;
			dataValid_q     <= 1'b0;
		end else begin
			singleSeen_q <= voltOnce | ampOnce;
			if (conversionDone) begin
				singlePending_q <= 1'b0;
				dataValid_q     <= 1'b1;
			end else if ((voltOnce | ampOnce) & ~singleSeen_q) begin
				singlePending_q <= 1'b1;
			end
		end
	end

	// Frame shape from the latest command
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			frame_q <= monitor_readback_pkg::FR_BOTH;
		end else if (phase_q == monitor_readback_pkg::PH_IDLE) begin
			if (statusReadSel)
				frame_q <= monitor_readback_pkg::FR_STATUS;
			else if ((volt_free_run | voltOnce) && !(amp_free_run | ampOnce))
				frame_q <= monitor_readback_pkg::FR_VOLT;
			else if ((amp_free_run | ampOnce) && !(volt_free_run | voltOnce))
				frame_q <= monitor_readback_pkg::FR_AMP;
			else
				frame_q <= monitor_readback_pkg::FR_BOTH;
		end
	end

	// Byte selection; zeros before the first continuous conversion
	always_comb begin
		txByte  = 8'h00;
		lastIdx = 2'h1;
		unique case (frame_q)
			monitor_readback_pkg::FR_BOTH: begin
				lastIdx = 2'h2;
				unique case (byteIdx_q)
					2'h0:    txByte = voltCode[11:4];
					2'h1:    txByte = ampCode[11:4];
					default: txByte = {voltCode[3:0], ampCode[3:0]};
				endcase
			end
			monitor_readback_pkg::FR_VOLT:
				txByte = (byteIdx_q == 2'h0) ? voltCode[11:4] : {voltCode[3:0], 4'h0};
			monitor_readback_pkg::FR_AMP:
				txByte = (byteIdx_q == 2'h0) ? ampCode[11:4] : {ampCode[3:0], 4'h0};
			monitor_readback_pkg::FR_STATUS: begin
				lastIdx = 2'h0;
				txByte  = alertStatus;
			end
		endcase
		if (frame_q != monitor_readback_pkg::FR_STATUS && !dataValid_q && freeRunNow)
			txByte = 8'h00;
	end

	// Serial slave phase machine; changes SDA only after SCL falls
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			phase_q   <= monitor_readback_pkg::PH_IDLE;
			bitCnt_q  <= 4'h0;
			shift_q   <= 8'h00;
			byteIdx_q <= 2'h0;
			sdaOut    <= 1'b1;
			sdaOe     <= 1'b0;
		end else if (startCond) begin
			phase_q   <= monitor_readback_pkg::PH_ADDR;
			bitCnt_q  <= 4'h0;
			byteIdx_q <= 2'h0;
			sdaOe     <= 1'b0;
		end else if (stopCond) begin
			phase_q <= monitor_readback_pkg::PH_IDLE;
			sdaOe   <= 1'b0;
		end else begin
			unique case (phase_q)
				monitor_readback_pkg::PH_IDLE: begin
					sdaOe <= 1'b0;
				end
				monitor_readback_pkg::PH_ADDR: begin
					if (sclRise) begin
						shift_q  <= {shift_q[6:0], sdaSync};
						bitCnt_q <= bitCnt_q + 4'h1;
					end else if (sclFall && bitCnt_q == 4'h8) begin
						// Answer only a read to our address with no single-shot pending
						if (shift_q[7:1] == slaveAddr && shift_q[0] && !singlePending_q) begin
							phase_q <= monitor_readback_pkg::PH_ADDR_ACK;
							sdaOut  <= 1'b0;
							sdaOe   <= 1'b1;
						end else begin
							phase_q <= monitor_readback_pkg::PH_SKIP;
						end
					end
				end
				monitor_readback_pkg::PH_ADDR_ACK: begin
					if (sclFall) begin
						phase_q  <= monitor_readback_pkg::PH_TX;
						shift_q  <= {txByte[6:0], 1'b0};
						sdaOut   <= txByte[7];
						sdaOe    <= ~txByte[7];
						bitCnt_q <= 4'h1;
					end
				end
				monitor_readback_pkg::PH_TX: begin
					if (sclFall) begin
						if (bitCnt_q == 4'h8) begin
							phase_q <= monitor_readback_pkg::PH_MACK;
							sdaOut  <= 1'b1;
							sdaOe   <= 1'b0;
						end else begin
							// Open drain: only a zero is driven
							sdaOut   <= shift_q[7];
							sdaOe    <= ~shift_q[7];
							shift_q  <= {shift_q[6:0], 1'b0};
							bitCnt_q <= bitCnt_q + 4'h1;
						end
					end
				end
				monitor_readback_pkg::PH_MACK: begin
					if (sclRise) begin
						// Master acknowledge continues until the last frame byte; not-acknowledge or the last byte ends
						if (!sdaSync && byteIdx_q != lastIdx) begin
							byteIdx_q <= byteIdx_q + 2'h1;
							phase_q   <= monitor_readback_pkg::PH_ADDR_ACK;
						end else begin
							phase_q <= monitor_readback_pkg::PH_SKIP;
						end
					end
				end
				monitor_readback_pkg::PH_SKIP: begin
					sdaOe <= 1'b0;
				end
			endcase
		end
	end

	// Registered copies of internal state for observation
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			alertStatusOut  <= `STAT_RESET_VALUE;
			clearPendingOut <= 1'b0;
			readActive      <= 1'b0;
		end else begin
			alertStatusOut  <= alertStatus;
			clearPendingOut <= clearPending;
			readActive      <= (phase_q != monitor_readback_pkg::PH_IDLE) &&
				(phase_q != monitor_readback_pkg::PH_SKIP);
		end
	end

endmodule
`default_nettype wire

//--- rtl/monitor_readback_params.svh
// Constants for the monitor readback status port
`ifndef MONITOR_READBACK_PARAMS_SVH
`define MONITOR_READBACK_PARAMS_SVH

// Status byte bit positions
`define STAT_SAMPLED_OC_BIT   0
`define STAT_ADC_ALERT_BIT    1
`define STAT_ANALOG_OFF_BIT   2
`define STAT_INS_FAIL_BIT     3
`define STAT_OFF_NOW_BIT      4
`define STAT_OFF_ALERT_BIT    5
`define STAT_RESET_VALUE      8'h00

// Serial framing
`define ADDR_BITS             7
`define DEFAULT_SLAVE_ADDR    7'h4A

`endif

//--- rtl/monitor_readback_pkg.sv
// Types shared by the monitor readback status port
`default_nettype none
package monitor_readback_pkg;

	// Serial slave phases
	typedef enum logic [2:0] {
		PH_IDLE,
		PH_ADDR,
		PH_ADDR_ACK,
		PH_TX,
		PH_MACK,
		PH_SKIP
	} phase_e;

	// Readback frame shape
	typedef enum logic [1:0] {
		FR_BOTH,
		FR_VOLT,
		FR_AMP,
		FR_STATUS
	} frame_e;

endpackage
`default_nettype wire

//--- rtl/pin_sync.sv
// Two-stage synchroniser for one asynchronous level
`default_nettype none
module pin_sync (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic arst_n,
	// Level in and out
	input  wire logic asyncIn,
	output var  logic syncOut
);

	logic stage1_q;

	// First stage feeds only the second
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			stage1_q <= 1'b1;
			syncOut  <= 1'b1;
		end else begin
			stage1_q <= asyncIn;
			syncOut  <= stage1_q;
		end
	end

endmodule
`default_nettype wire

//--- rtl/alert_status_flags.sv
// Alert status byte with sticky flags and self-clearing clear control
`include "monitor_readback_params.svh"
`default_nettype none
module alert_status_flags (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       arst_n,
	// Alert sources (same clock domain)
	input  wire logic       sampled_overcurrent_now,
	input  wire logic       adcTripEvent,
	input  wire logic       analog_trip_off_state,
	input  wire logic       insertionFailEvent,
	input  wire logic       latchOffVariant,
	input  wire logic       insertion_fail_notice_on,
	input  wire logic       powerRequestOff,
	input  wire logic       soft_power_down,
	input  wire logic       offAlertEvent,
	// Clear control
	input  wire logic       clearRequest,
	output var  logic       clearPending,
	// Status byte
	output var  logic [7:0] alertStatus
);

	logic adcAlert_q;
	logic insertion_fail_flag;
	logic offAlert_q;

	// Clear control self-clears once the sticky bits were cleared
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			clearPending <= 1'b0;
		end else begin
			clearPending <= clearRequest & ~clearPending;
		end
	end

	// Sticky flags; a new event in the clear cycle still sets the flag
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			adcAlert_q          <= 1'b0;
			insertion_fail_flag <= 1'b0;
			offAlert_q          <= 1'b0;
		end else begin
			adcAlert_q          <= adcTripEvent | (adcAlert_q & ~clearPending);
			insertion_fail_flag <= insertionFailEvent | (insertion_fail_flag & ~clearPending);
			offAlert_q          <= offAlertEvent | (offAlert_q & ~clearPending);
		end
	end

	// Status byte; top two bits zero, no write path exists
	always_comb begin
		alertStatus = `STAT_RESET_VALUE;
		alertStatus[`STAT_SAMPLED_OC_BIT] = sampled_overcurrent_now;
		alertStatus[`STAT_ADC_ALERT_BIT]  = adcAlert_q;
		// Latch-off parts mirror the sticky fail flag when its alert is on
		alertStatus[`STAT_ANALOG_OFF_BIT] = (latchOffVariant && insertion_fail_notice_on) ?
			insertion_fail_flag : analog_trip_off_state;
		alertStatus[`STAT_INS_FAIL_BIT]   = insertion_fail_flag;
		alertStatus[`STAT_OFF_NOW_BIT]    = powerRequestOff | soft_power_down;
		alertStatus[`STAT_OFF_ALERT_BIT]  = offAlert_q;
	end

endmodule
`default_nettype wire

//--- verification/i2c_master_model.sv
// Behavioural two-wire bus master that drives the serial pins of the port
`default_nettype none
module i2c_master_model (
	// Clock
	input  wire logic ref_clk,
	// Slave data drive
	input  wire logic sdaOut,
	input  wire logic sdaOe,
	// Bus lines seen by the slave
	output var  logic sclIn,
	output var  logic sdaIn
);
	timeunit 1ns;
	timeprecision 1ps;
	logic mLow = 1'b0;
	initial sclIn = 1'b1;
	// Pulled-up wire: low when either party pulls it down
	always_comb sdaIn = !mLow && !(sdaOe && !sdaOut);
	// Quarter of a 400 ns bit period; the clock stands still between frames
	task automatic q();
		repeat (2) @(negedge ref_clk);
	endtask
	// Data falls while the clock is high
	task automatic start();
		mLow = 1'b0;
		sclIn = 1'b1;
		q();
		mLow = 1'b1;
		q();
		sclIn = 1'b0;
		q();
	endtask
	// Data rises while the clock is high
	task automatic stop();
		mLow = 1'b1;
		q();
		sclIn = 1'b1;
		q();
		mLow = 1'b0;
		q();
	endtask
	// Master changes data only while the clock is low, samples mid-high
	task automatic bitx(input logic b, output logic r);
		mLow = !b;
		q();
		sclIn = 1'b1;
		q();
		r = sdaIn;
		q();
		sclIn = 1'b0;
		q();
	endtask
	task automatic wrByte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(b[i], r);
		bitx(1'b1, r);
		ack = !r;
	endtask
	// Line released for the slave's bits, then ack or not-ack
	task automatic rdByte(input logic mack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
		bitx(!mack, r);
	endtask
endmodule
`default_nettype wire

//--- verification/monitor_readback_port_asserts.sv
// Concurrent checks on the monitor readback status port
`default_nettype none
module monitor_readback_checker (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       arst_n,
	// Serial data drive
	input  wire logic       sdaOut,
	input  wire logic       sdaOe,
	input  wire logic       readActive,
	// Alert sources and clear
	input  wire logic       sampled_overcurrent_now,
	input  wire logic       adcTripEvent,
	input  wire logic       analog_trip_off_state,
	input  wire logic       latchOffVariant,
	input  wire logic       insertion_fail_notice_on,
	input  wire logic       powerRequestPin,
	input  wire logic       soft_power_down,
	input  wire logic       clearRequest,
	// Observed state
	input  wire logic [7:0] alertStatusOut,
	input  wire logic       clearPendingOut
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	a_top_bits_zero: assert property (alertStatusOut[7:6] == 2'b00) else $error("Status top bits set");
	a_drive_low_only: assert property (sdaOe |-> !sdaOut) else $error("Data driven high");
	a_idle_release: assert property (!readActive |-> !sdaOe) else $error("Data driven while idle");
	a_overcur_shown: assert property ($rose(sampled_overcurrent_now) |-> ##[1:5] alertStatusOut[0])
		else $error("Overcurrent level not shown");
	a_adc_sticky_set: assert property (adcTripEvent |-> ##[1:4] alertStatusOut[1])
		else $error("Trip flag not set");
	a_sticky_clear_cause: assert property (($fell(alertStatusOut[1]) || $fell(alertStatusOut[3])
		|| $fell(alertStatusOut[5])) |-> ($past(clearPendingOut) || $past(clearPendingOut, 2)
		|| $past(clearPendingOut, 3))) else $error("Sticky flag lost without clear");
	a_clear_pulse: assert property ($rose(clearRequest) |-> ##[1:3] clearPendingOut)
		else $error("Clear not started");
	a_clear_self_ends: assert property (clearPendingOut |=> !clearPendingOut) else $error("Clear stuck");
	a_power_off_shown: assert property ($stable({powerRequestPin, soft_power_down})[*7]
		|-> alertStatusOut[4] == (!powerRequestPin || soft_power_down)) else $error("Off state wrong");
	a_mirror_fail: assert property ((latchOffVariant && insertion_fail_notice_on)[*6]
		|-> alertStatusOut[2] == alertStatusOut[3]) else $error("Latch-off bit not mirrored");
	a_present_trip: assert property ((!latchOffVariant && $stable(analog_trip_off_state))[*7]
		|-> alertStatusOut[2] == analog_trip_off_state) else $error("Trip-off state wrong");
endmodule
bind monitor_readback_port monitor_readback_checker u_monitor_readback_checker (.ref_clk(ref_clk),
	.arst_n(arst_n), .sdaOut(sdaOut), .sdaOe(sdaOe), .readActive(readActive),
	.sampled_overcurrent_now(sampled_overcurrent_now), .adcTripEvent(adcTripEvent),
	.analog_trip_off_state(analog_trip_off_state), .latchOffVariant(latchOffVariant),
	.insertion_fail_notice_on(insertion_fail_notice_on), .powerRequestPin(powerRequestPin),
	.soft_power_down(soft_power_down), .clearRequest(clearRequest), .alertStatusOut(alertStatusOut),
	.clearPendingOut(clearPendingOut));
`default_nettype wire

//--- verification/monitor_readback_port_tb_top.sv
// Self-checking bench for the monitor readback status port
`include "monitor_readback_params.svh"
`default_nettype none
module monitor_readback_port_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// Design pins
	logic ref_clk = 1'b0, arst_n = 1'b0, sclIn, sdaIn, sdaOut, sdaOe, clearPendingOut, readActive;
	logic [6:0] slaveAddr = `DEFAULT_SLAVE_ADDR;
	logic volt_free_run = 1'b0, voltOnce = 1'b0, amp_free_run = 1'b0, ampOnce = 1'b0;
	logic statusReadSel = 1'b0, voltage_span_select = 1'b0, conversionDone = 1'b0;
	logic [11:0] voltCode = 12'h000, ampCode = 12'h000;
	logic sampled_overcurrent_now = 1'b0, adcTripEvent = 1'b0, analog_trip_off_state = 1'b0;
	logic insertionFailEvent = 1'b0, latchOffVariant = 1'b0, insertion_fail_notice_on = 1'b0;
	logic powerRequestPin = 1'b1, soft_power_down = 1'b0, offAlertEvent = 1'b0, clearRequest = 1'b0;
	logic [7:0] alertStatusOut;
	int errTotal = 0, checksDone = 0, cyc = 0;
	logic [31:0] seed = 32'h0000BF39;
	monitor_readback_port u_monitor_readback_port (.ref_clk(ref_clk), .arst_n(arst_n), .sclIn(sclIn),
		.sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .slaveAddr(slaveAddr), .volt_free_run(volt_free_run),
		.voltOnce(voltOnce), .amp_free_run(amp_free_run), .ampOnce(ampOnce), .statusReadSel(statusReadSel),
		.voltage_span_select(voltage_span_select), .voltCode(voltCode), .ampCode(ampCode),
		.conversionDone(conversionDone), .sampled_overcurrent_now(sampled_overcurrent_now),
		.adcTripEvent(adcTripEvent), .analog_trip_off_state(analog_trip_off_state),
		.insertionFailEvent(insertionFailEvent), .latchOffVariant(latchOffVariant),
		.insertion_fail_notice_on(insertion_fail_notice_on), .powerRequestPin(powerRequestPin),
		.soft_power_down(soft_power_down), .offAlertEvent(offAlertEvent), .clearRequest(clearRequest),
		.alertStatusOut(alertStatusOut), .clearPendingOut(clearPendingOut), .readActive(readActive));
	i2c_master_model u_i2c_master_model (.ref_clk(ref_clk), .sdaOut(sdaOut), .sdaOe(sdaOe), .sclIn(sclIn),
		.sdaIn(sdaIn));
	always #25 ref_clk = !ref_clk;
	// Cut a hung run short; the sequence needs well under a third of this
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 30000) begin
			errTotal++;
			$display("MISMATCH t=%0t run timed out", $time);
			report_and_stop();
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Expected frame bytes, left aligned, for both, voltage-only, current-only
	function automatic logic [23:0] expData(input int m, input logic [11:0] v, input logic [11:0] a);
		case (m)
			0: return {v[11:4], a[11:4], v[3:0], a[3:0]};
			1: return {v[11:4], v[3:0], 4'h0, 8'h00};
			default: return {a[11:4], a[3:0], 4'h0, 8'h00};
		endcase
	endfunction
	task automatic chk(input logic [24:0] got, input logic [24:0] exp, input string what);
		checksDone++;
		if (got !== exp) begin
			errTotal++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic convDone();
		conversionDone = 1'b1;
		tick(1);
		conversionDone = 1'b0;
	endtask
	// One whole read: address, n bytes, closing ack choice, stop
	task automatic readFrame(input logic [7:0] adr, input int n, input logic lastAck, output logic ack,
		output logic [23:0] d);
		logic [7:0] b;
		d = 24'h000000;
		u_i2c_master_model.start();
		u_i2c_master_model.wrByte(adr, ack);
		for (int k = 0; k < n && ack; k++) begin
			u_i2c_master_model.rdByte(k < n - 1 || lastAck, b);
			d[23 - 8 * k -: 8] = b;
		end
		u_i2c_master_model.stop();
	endtask
	// lv holds {clear, events, notice, latch-off, soft off, request, trip off, overcurrent}
	task automatic statStep(input logic [7:0] lv, input logic [7:0] exp);
		logic ack;
		logic [23:0] d;
		{insertion_fail_notice_on, latchOffVariant, soft_power_down, powerRequestPin, analog_trip_off_state,
			sampled_overcurrent_now} = lv[5:0];
		{adcTripEvent, insertionFailEvent, offAlertEvent, clearRequest} = {lv[6], lv[6], lv[6], lv[7]};
		tick(1);
		{adcTripEvent, insertionFailEvent, offAlertEvent, clearRequest} = 4'h0;
		tick(8);
		chk({17'h00000, alertStatusOut}, {17'h00000, exp}, "status port");
		readFrame({slaveAddr, 1'b1}, 1, 1'b1, ack, d);
		chk({ack, d}, {1'b1, exp, 16'h0000}, "status read");
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checksDone, errTotal);
		if (errTotal == 0 && checksDone > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		logic ack;
		logic [23:0] d;
		int m;
		tick(6);
		arst_n = 1'b1;
		tick(4);
		chk({17'h00000, alertStatusOut}, {17'h00000, `STAT_RESET_VALUE}, "reset value");
		volt_free_run = 1'b1;
		amp_free_run = 1'b1;
		readFrame({slaveAddr, 1'b1}, 3, 1'b0, ack, d);
		chk({ack, d}, 25'h1000000, "read before conversion");
		$display("early read test done");
		for (int i = 0; i < 9; i++) begin
			m = i % 3;
			seed = lfsr(seed);
			voltCode = (i < 3) ? 12'hFFF : seed[11:0];
			ampCode = (i < 3) ? 12'h001 : seed[23:12];
			voltage_span_select = seed[24];
			volt_free_run = (m != 2);
			amp_free_run = (m != 1);
			convDone();
			readFrame({slaveAddr, 1'b1}, (m == 0) ? 3 : 2, 1'b0, ack, d);
			chk({ack, d}, {1'b1, expData(m, voltCode, ampCode)}, "frame");
		end
		$display("frame tests done");
		readFrame({slaveAddr ^ 7'h01, 1'b1}, 2, 1'b0, ack, d);
		chk({24'h000000, ack}, 25'h0000000, "foreign address");
		readFrame({slaveAddr, 1'b0}, 2, 1'b0, ack, d);
		chk({24'h000000, ack}, 25'h0000000, "write direction");
		volt_free_run = 1'b0;
		amp_free_run = 1'b0;
		for (int j = 1; j < 3; j++) begin
			voltOnce = (j == 1);
			ampOnce = (j == 2);
			tick(2);
			readFrame({slaveAddr, 1'b1}, 2, 1'b0, ack, d);
			chk({24'h000000, ack}, 25'h0000000, "single shot pending");
			convDone();
			readFrame({slaveAddr, 1'b1}, 2, 1'b0, ack, d);
			chk({ack, d}, {1'b1, expData(j, voltCode, ampCode)}, "single shot result");
			voltOnce = 1'b0;
			ampOnce = 1'b0;
			// Two idle cycles so the next one-shot bit is seen as a fresh request
			tick(2);
		end
		$display("refusal tests done");
		statusReadSel = 1'b1;
		statStep(8'h43, 8'h3F);
		statStep(8'h04, 8'h2A);
		statStep(8'h84, 8'h00);
		statStep(8'h7C, 8'h3E);
		statStep(8'hBC, 8'h10);
		$display("status tests done");
		report_and_stop();
	end
endmodule
`default_nettype wire
